// >>> inc/pes_defines.svh
// constants of the program and erase sequencer
// Summary of operation
// - begin-programming writes the loaded word at the current address, no erase
// - write lasts until end-programming arrives; programmer waits the write time
// - bulk erase clears the whole program array and the option word
// - every erased program location reads back all ones
// - bulk erase also clears the trim literal at the reset vector
// - bulk erase is self timed; programmer waits the erase time
// - erase from option word or program space spares user ids and backup trim
// - erase issued at first user id location also clears ids and backup trim
// - option bits read zero when programmed, one when unprogrammed
// - upper six option bits are unimplemented and read as ones
// - option bit 5 picks master reset input or general input
// - option bit 4 one leaves read protection off, zero turns it on
// - option bit 3 one enables the watchdog, zero disables it
// - option bits 2 to 0 select the oscillator source
// - codes 0..3 pick low power, standard, high speed crystal, external clock
// - mode entry presets the address counter to the option word location
// - six bit commands, lsb first, sampled on falling programming clock edge
`ifndef PES_DEFINES_SVH
`define PES_DEFINES_SVH

// command codes, low four bits of the six bit command
`define CMD_LOAD 4'h2
`define CMD_READ 4'h4
`define CMD_INC 4'h6
`define CMD_BEGIN 4'h8
`define CMD_END 4'he
`define CMD_ERASE 4'h9

// link framing
`define CMD_BITS 5'h06
`define DATA_CLOCKS 5'h10

// address map
`define ADDR_PROG_TOP 11'h3ff
`define ADDR_USER_ID0 11'h400
`define ADDR_USER_LAST 11'h403
`define ADDR_BACKUP_TRIM 11'h404
`define ADDR_OPTION 11'h7ff
`define PROG_DEPTH 1024

// option word layout
`define OPT_MASTER_RESET_BIT 5
`define OPT_READ_PROTECT_BIT 4
`define OPT_WATCHDOG_BIT 3
`define OPT_OSC_MSB 2
`define OPT_OSC_LSB 0
`define OPT_PAD 6'h3f
`define OSC_LOW_POWER 3'h0
`define OSC_STANDARD 3'h1
`define OSC_HIGH_SPEED 3'h2
`define OSC_EXTERNAL 3'h3
`define ERASED_WORD 12'hfff

// timing
`define MCLK_PERIOD_NS 25
`define ERASE_TIME_NS 2000000
`define ERASE_CYCLES \
  ((`ERASE_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// >>> inc/pes_pkg.sv
// types of the program and erase sequencer
`include "pes_defines.svh"
package pes_pkg;

  typedef enum logic [1:0] {S_IDLE, S_WRITE, S_ERASE} seq_state_t;

  typedef struct packed {
    logic [1:0] rst_pipe;
    logic data_phase;
    logic [4:0] bit_cnt;
    logic [15:0] shift;
    logic [5:0] cmd;
    logic [11:0] word;
    logic toggle;
  } link_state_t;

  typedef struct packed {
    logic [1:0] pipe;
  } sync_state_t;

  typedef struct packed {
    seq_state_t st;
    logic [10:0] addr;
    logic option_hidden;
    logic [11:0] latch;
    logic [5:0] option;
    logic [3:0][11:0] user_id;
    logic [11:0] backup_trim;
    logic [`PROG_DEPTH-1:0][11:0] mem;
    logic [23:0] cnt;
    logic full_erase;
    logic toggle_seen;
    logic [11:0] fetch;
    logic [11:0] option_out;
    logic [10:0] addr_out;
    logic write_out;
    logic erase_out;
    logic [5:0] flags;
    logic [3:0] osc;
    logic core_rst_b;
  } seq_state_s_t;

endpackage

// >>> design/bit_sync.sv
// two stage synchroniser for levels entering the system clock domain
`timescale 1ns/10ps
module bit_sync
  import pes_pkg::*;
(
  input wire logic clk, // destination clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic d, // asynchronous level
  output logic q // synchronised level
);

  sync_state_t s;
  sync_state_t next_s;

  // only the second stage is ever read
  always_comb begin
    next_s.pipe = {s.pipe[0], d};
    if (!rst_b) begin
      next_s.pipe = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign q = s.pipe[1];

endmodule

// >>> design/link_shifter.sv
// serial command and data shifter on the programming clock
`timescale 1ns/10ps
module link_shifter
  import pes_pkg::*;
(
  input wire logic prog_clk, // programming clock from the programmer
  input wire logic rst_b, // system reset, asynchronous to prog_clk
  input wire logic prog_data, // serial data, lsb first
  output logic [5:0] cmd, // last complete command
  output logic [11:0] word, // last loaded data word
  output logic toggle // flips once per posted command other than read
);

  link_state_t s;
  link_state_t next_s;

  // one falling edge is one bit; word, and the cmd of a command with no data, update on the same edge that toggle flips
  always_comb begin
    next_s = s;
    next_s.rst_pipe = {s.rst_pipe[0], rst_b};
    next_s.shift = {prog_data, s.shift[15:1]};
    next_s.bit_cnt = s.bit_cnt + 5'h01;
    if (!s.data_phase) begin
      if (next_s.bit_cnt == `CMD_BITS) begin
        next_s.cmd = next_s.shift[15:10];
        next_s.bit_cnt = 5'h00;
        if (next_s.shift[13:10] == `CMD_LOAD ||
            next_s.shift[13:10] == `CMD_READ) begin
          next_s.data_phase = 1'b1;
        end else begin
          next_s.toggle = ~s.toggle;
        end
      end
    end else if (next_s.bit_cnt == `DATA_CLOCKS) begin
      // start bit sits in shift[0], the 12 used data bits above it
      next_s.bit_cnt = 5'h00;
      next_s.data_phase = 1'b0;
      if (s.cmd[3:0] == `CMD_LOAD) begin
        next_s.word = next_s.shift[12:1];
        next_s.toggle = ~s.toggle;
      end
    end
    // reset needs falling edges; a stopped clock keeps the old frame state
    if (!s.rst_pipe[1]) begin
      next_s.data_phase = 1'b0;
      next_s.bit_cnt = 5'h00;
      next_s.shift = 16'h0000;
      next_s.cmd = 6'h00;
      next_s.word = `ERASED_WORD;
      next_s.toggle = 1'b0;
    end
  end

  always_ff @(negedge prog_clk) begin
    s <= next_s;
  end

  assign cmd = s.cmd;
  assign word = s.word;
  assign toggle = s.toggle;

endmodule

// >>> design/prog_erase_seq.sv
// program and erase sequencer with option word decode
`timescale 1ns/10ps
module prog_erase_seq
  import pes_pkg::*;
#(
  parameter int ERASE_CYCLES = `ERASE_CYCLES // erase duration in MCLK cycles
)
(
  input wire logic MCLK, // system clock, 40 MHz
  input wire logic RST_B, // synchronous reset, mode entry
  input wire logic PROG_CLK, // programming clock from the programmer
  input wire logic PROG_DATA, // programming serial data in
  input wire logic MASTER_RESET_INPUT_B, // shared reset pin level
  input wire logic [9:0] FETCH_ADDR, // core read address
  output logic [11:0] FETCH_DATA, // program word at FETCH_ADDR
  output logic [11:0] DEVICE_OPTION_WORD, // option word readback
  output logic [10:0] ADDRESS, // address counter
  output logic WRITE_ACTIVE, // write cycle in progress
  output logic ERASE_ACTIVE, // bulk erase in progress
  output logic MASTER_RESET_PIN_SELECT, // pin is master reset input
  output logic READ_PROTECT_SELECT, // one = protection off
  output logic WATCHDOG_ENABLE_BIT, // watchdog enabled
  output logic [2:0] OSCILLATOR_SOURCE_FIELD, // oscillator code
  output logic LOW_POWER_CRYSTAL, // code 000
  output logic STANDARD_CRYSTAL, // code 001
  output logic HIGH_SPEED_CRYSTAL, // code 010
  output logic EXTERNAL_CLOCK_INPUT, // code 011
  output logic SHARED_GENERAL_INPUT, // reset pin used as general input
  output logic SHARED_GENERAL_IO, // clock-out pin kept as general io
  output logic CORE_RESET_B // internal reset, active low
);

  //////////////////////////////////////////////////////////////////////////

  seq_state_s_t s;
  seq_state_s_t next_s;
  logic [5:0] link_cmd;
  logic [11:0] link_word;
  logic link_toggle;
  logic toggle_sync;
  logic pin_rst_sync;
  logic cmd_event;
  logic [3:0] cmd_code;

  // serial link on its own clock; only a toggle and held words cross
  link_shifter u_link (
    .prog_clk(PROG_CLK),
    .rst_b(RST_B),
    .prog_data(PROG_DATA),
    .cmd(link_cmd),
    .word(link_word),
    .toggle(link_toggle)
  );

  // command event crossing, toggle style
  bit_sync u_cmd_sync (
    .clk(MCLK),
    .rst_b(RST_B),
    .d(link_toggle),
    .q(toggle_sync)
  );

  // shared reset pin is asynchronous to MCLK
  bit_sync u_pin_sync (
    .clk(MCLK),
    .rst_b(RST_B),
    .d(MASTER_RESET_INPUT_B),
    .q(pin_rst_sync)
  );

  //////////////////////////////////////////////////////////////////////////

  // counter steps 0x3ff to 0x400 and wraps 0x7ff to 0x000
  function automatic logic [10:0] step_addr(input logic [10:0] a);
    logic [10:0] r;
    r = a + 11'h001;
    if (a == `ADDR_OPTION) begin
      r = 11'h000;
    end
    return r;
  endfunction

  // flash cells only go from one to zero without an erase
  function automatic logic [11:0] burn(input logic [11:0] old,
                                       input logic [11:0] val);
    return old & val;
  endfunction

  // oscillator code decode, one hot of the four crystal and clock modes
  function automatic logic [3:0] osc_decode(input logic [2:0] f);
    logic [3:0] r;
    r = 4'h0;
    case (f)
      `OSC_LOW_POWER: r = 4'h1;
      `OSC_STANDARD: r = 4'h2;
      `OSC_HIGH_SPEED: r = 4'h4;
      `OSC_EXTERNAL: r = 4'h8;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////

  assign cmd_event = toggle_sync != s.toggle_seen;
  assign cmd_code = link_cmd[3:0];

  // sequencer and array update
  always_comb begin
    next_s = s;
    next_s.toggle_seen = toggle_sync;
    case (s.st)
      S_IDLE: begin
        if (cmd_event) begin
          case (cmd_code)
            `CMD_LOAD: begin
              next_s.latch = link_word;
            end
            `CMD_INC: begin
              next_s.addr = step_addr(s.addr);
              next_s.option_hidden = 1'b1;
            end
            `CMD_BEGIN: begin
              // program at decode, no erase of the location first
              next_s.st = S_WRITE;
              if (s.addr <= `ADDR_PROG_TOP) begin
                next_s.mem[s.addr[9:0]] =
                  burn(s.mem[s.addr[9:0]], s.latch);
              end else if (s.addr <= `ADDR_USER_LAST) begin
                next_s.user_id[s.addr[1:0]] =
                  burn(s.user_id[s.addr[1:0]], s.latch);
              end else if (s.addr == `ADDR_BACKUP_TRIM) begin
                next_s.backup_trim = burn(s.backup_trim, s.latch);
              end else if (s.addr == `ADDR_OPTION && !s.option_hidden) begin
                next_s.option = s.option & s.latch[5:0];
              end
            end
            `CMD_ERASE: begin
              next_s.st = S_ERASE;
              next_s.cnt = 24'h000000;
              next_s.full_erase = s.addr == `ADDR_USER_ID0;
            end
            default: begin
              // read, stray end and unknown codes change nothing here
            end
          endcase
        end
      end
      S_WRITE: begin
        // only the terminating command is heard while writing
        if (cmd_event && cmd_code == `CMD_END) begin
          next_s.st = S_IDLE;
        end
      end
      S_ERASE: begin
        // self timed; every command arriving now is dropped
        if (s.cnt == 24'(ERASE_CYCLES - 1)) begin
          next_s.st = S_IDLE;
          next_s.mem = '1;
          next_s.option = `OPT_PAD;
          if (s.full_erase) begin
            next_s.user_id = '1;
            next_s.backup_trim = `ERASED_WORD;
          end
        end else begin
          next_s.cnt = s.cnt + 24'h000001;
        end
      end
      default: begin
        next_s.st = S_IDLE;
      end
    endcase
    // entry reset; the array comes up erased since flops hold no charge
    if (!RST_B) begin
      next_s.st = S_IDLE;
      next_s.addr = `ADDR_OPTION;
      next_s.option_hidden = 1'b0;
      next_s.latch = `ERASED_WORD;
      next_s.option = `OPT_PAD;
      next_s.user_id = '1;
      next_s.backup_trim = `ERASED_WORD;
      next_s.mem = '1;
      next_s.cnt = 24'h000000;
      next_s.full_erase = 1'b0;
      next_s.toggle_seen = 1'b0;
    end
    // registered outputs, taken from the values just computed
    next_s.fetch = next_s.mem[FETCH_ADDR];
    next_s.option_out = {`OPT_PAD, next_s.option};
    next_s.addr_out = next_s.addr;
    next_s.write_out = next_s.st == S_WRITE;
    next_s.erase_out = next_s.st == S_ERASE;
    next_s.flags = next_s.option;
    next_s.osc =
      osc_decode(next_s.option[`OPT_OSC_MSB:`OPT_OSC_LSB]);
    // bit 5 low ties the internal reset inactive
    next_s.core_rst_b = next_s.option[`OPT_MASTER_RESET_BIT] ?
      pin_rst_sync : 1'b1;
  end

  always_ff @(posedge MCLK) begin
    s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////////

  // outputs straight from the state flops
  assign FETCH_DATA = s.fetch;
  assign DEVICE_OPTION_WORD = s.option_out;
  assign ADDRESS = s.addr_out;
  assign WRITE_ACTIVE = s.write_out;
  assign ERASE_ACTIVE = s.erase_out;
  assign MASTER_RESET_PIN_SELECT = s.flags[`OPT_MASTER_RESET_BIT];
  assign SHARED_GENERAL_INPUT = ~s.flags[`OPT_MASTER_RESET_BIT];
  assign READ_PROTECT_SELECT = s.flags[`OPT_READ_PROTECT_BIT];
  assign WATCHDOG_ENABLE_BIT = s.flags[`OPT_WATCHDOG_BIT];
  assign OSCILLATOR_SOURCE_FIELD =
    s.flags[`OPT_OSC_MSB:`OPT_OSC_LSB];
  assign LOW_POWER_CRYSTAL = s.osc[0];
  assign STANDARD_CRYSTAL = s.osc[1];
  assign HIGH_SPEED_CRYSTAL = s.osc[2];
  assign EXTERNAL_CLOCK_INPUT = s.osc[3];
  assign SHARED_GENERAL_IO = s.osc[3];
  assign CORE_RESET_B = s.core_rst_b;

endmodule

// >>> testbench/pes_assertions.sv
// port-level checks for the program and erase sequencer
`timescale 1ns/10ps
module pes_checker #(
  parameter int ERASE_CYCLES = 20 // erase length in MCLK cycles
)
(
  input wire logic MCLK, // system clock
  input wire logic RST_B, // sync reset, active low
  input wire logic [11:0] DEVICE_OPTION_WORD, // option readback
  input wire logic [10:0] ADDRESS, // address counter
  input wire logic WRITE_ACTIVE, // write cycle
  input wire logic ERASE_ACTIVE, // bulk erase
  input wire logic MASTER_RESET_PIN_SELECT, // option bit 5
  input wire logic READ_PROTECT_SELECT, // option bit 4
  input wire logic WATCHDOG_ENABLE_BIT, // option bit 3
  input wire logic [2:0] OSCILLATOR_SOURCE_FIELD, // option bits 2:0
  input wire logic LOW_POWER_CRYSTAL, // code 000
  input wire logic STANDARD_CRYSTAL, // code 001
  input wire logic HIGH_SPEED_CRYSTAL, // code 010
  input wire logic EXTERNAL_CLOCK_INPUT, // code 011
  input wire logic SHARED_GENERAL_INPUT, // pin as input
  input wire logic SHARED_GENERAL_IO, // clock pin as io
  input wire logic CORE_RESET_B // internal reset
);
  logic [23:0] ecnt;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // cycles of the running erase, so its length is seen at the fall
  always_ff @(posedge MCLK) begin
    if (!RST_B || !ERASE_ACTIVE) ecnt <= 24'h0;
    else ecnt <= ecnt + 24'h1;
  end
  ////////////////////////////////////////////////////////////
  a_upper_ones: assert property (DEVICE_OPTION_WORD[11:6] == 6'h3f)
    else $error("upper option bits not ones");
  a_pin_role: assert property (MASTER_RESET_PIN_SELECT ==
    DEVICE_OPTION_WORD[5] && SHARED_GENERAL_INPUT == !DEVICE_OPTION_WORD[5])
    else $error("pin role mismatch");
  a_protect_bit: assert property (READ_PROTECT_SELECT ==
    DEVICE_OPTION_WORD[4]) else $error("protect bit mismatch");
  a_watchdog_bit: assert property (WATCHDOG_ENABLE_BIT ==
    DEVICE_OPTION_WORD[3]) else $error("watchdog bit mismatch");
  a_osc_field: assert property (OSCILLATOR_SOURCE_FIELD ==
    DEVICE_OPTION_WORD[2:0]) else $error("osc field mismatch");
  a_osc_decode: assert property ({EXTERNAL_CLOCK_INPUT,
    HIGH_SPEED_CRYSTAL, STANDARD_CRYSTAL, LOW_POWER_CRYSTAL} ==
    (OSCILLATOR_SOURCE_FIELD[2] ? 4'h0 : 4'h1 << OSCILLATOR_SOURCE_FIELD[1:0])
    && SHARED_GENERAL_IO == EXTERNAL_CLOCK_INPUT)
    else $error("osc decode wrong");
  a_erase_len: assert property ($fell(ERASE_ACTIVE) |->
    ecnt == ERASE_CYCLES) else $error("erase length wrong");
  a_erase_clear: assert property ($fell(ERASE_ACTIVE) |->
    ##[0:1] DEVICE_OPTION_WORD == 12'hfff) else $error("option not erased");
  a_one_op: assert property (!(WRITE_ACTIVE && ERASE_ACTIVE))
    else $error("write and erase overlap");
  a_addr_frozen: assert property (WRITE_ACTIVE && $past(WRITE_ACTIVE)
    |-> $stable(ADDRESS)) else $error("address moved in write");
  a_entry_addr: assert property ($rose(RST_B) |->
    ADDRESS == 11'h7ff) else $error("entry address wrong");
  a_core_tied: assert property (!MASTER_RESET_PIN_SELECT &&
    $past(MASTER_RESET_PIN_SELECT) == 1'h0 |-> CORE_RESET_B)
    else $error("core reset not tied off");
endmodule
bind prog_erase_seq pes_checker #(.ERASE_CYCLES(ERASE_CYCLES)) pes_checker_i (
  .MCLK(MCLK), .RST_B(RST_B), .DEVICE_OPTION_WORD(DEVICE_OPTION_WORD),
  .ADDRESS(ADDRESS), .WRITE_ACTIVE(WRITE_ACTIVE),
  .ERASE_ACTIVE(ERASE_ACTIVE),
  .MASTER_RESET_PIN_SELECT(MASTER_RESET_PIN_SELECT),
  .READ_PROTECT_SELECT(READ_PROTECT_SELECT),
  .WATCHDOG_ENABLE_BIT(WATCHDOG_ENABLE_BIT),
  .OSCILLATOR_SOURCE_FIELD(OSCILLATOR_SOURCE_FIELD),
  .LOW_POWER_CRYSTAL(LOW_POWER_CRYSTAL), .STANDARD_CRYSTAL(STANDARD_CRYSTAL),
  .HIGH_SPEED_CRYSTAL(HIGH_SPEED_CRYSTAL),
  .EXTERNAL_CLOCK_INPUT(EXTERNAL_CLOCK_INPUT),
  .SHARED_GENERAL_INPUT(SHARED_GENERAL_INPUT),
  .SHARED_GENERAL_IO(SHARED_GENERAL_IO), .CORE_RESET_B(CORE_RESET_B));

// >>> testbench/prog_model.sv
// programmer model driving the serial programming link
`timescale 1ns/10ps
module prog_model (
  output logic pclk = 1'h0, // programming clock, still between frames
  output logic pdata = 1'h0 // serial data, lsb first
);
  // 12 ns bit clock; data settles well before the falling edge
  task automatic clk_bits(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      pdata = v[i];
      #3 pclk = 1'h1;
      #6 pclk = 1'h0;
      #3;
    end
    pdata = ~pdata; // no stale level left after the frame
  endtask
  // gap covers the crossing and the discharge delay
  task automatic send_cmd(input logic [5:0] c);
    clk_bits({10'h000, c}, 6);
    #200;
  endtask
  // load: command, pause, start, 12 data, two zeros, stop
  task automatic send_load(input logic [11:0] w);
    clk_bits(16'h0002, 6);
    #100;
    clk_bits({3'h0, w, 1'h0}, 16);
    #200;
  endtask
endmodule

// >>> testbench/prog_erase_seq_tb.sv
// self-checking bench for the program and erase sequencer
`timescale 1ns/10ps
module prog_erase_seq_tb;
  import pes_pkg::*;
  localparam int EC = 20;
  typedef struct {int sel; logic [11:0] val;} note_t;
  logic MCLK, RST_B, PROG_CLK, PROG_DATA, MASTER_RESET_INPUT_B;
  logic [9:0] FETCH_ADDR;
  logic [11:0] FETCH_DATA, DEVICE_OPTION_WORD, t;
  logic [10:0] ADDRESS;
  logic [2:0] OSCILLATOR_SOURCE_FIELD;
  logic WRITE_ACTIVE, ERASE_ACTIVE, MASTER_RESET_PIN_SELECT, CORE_RESET_B;
  logic READ_PROTECT_SELECT, WATCHDOG_ENABLE_BIT, LOW_POWER_CRYSTAL;
  logic STANDARD_CRYSTAL, HIGH_SPEED_CRYSTAL, EXTERNAL_CLOCK_INPUT;
  logic SHARED_GENERAL_INPUT, SHARED_GENERAL_IO;
  logic [5:0] v;
  note_t q[$];
  note_t n;
  int n_mismatch = 0;
  int samples_checked = 0;
  prog_model prog_model_i (.pclk(PROG_CLK), .pdata(PROG_DATA));
  prog_erase_seq #(.ERASE_CYCLES(EC)) prog_erase_seq_i (
    .MCLK(MCLK), .RST_B(RST_B), .PROG_CLK(PROG_CLK), .PROG_DATA(PROG_DATA),
    .MASTER_RESET_INPUT_B(MASTER_RESET_INPUT_B), .FETCH_ADDR(FETCH_ADDR),
    .FETCH_DATA(FETCH_DATA), .DEVICE_OPTION_WORD(DEVICE_OPTION_WORD),
    .ADDRESS(ADDRESS), .WRITE_ACTIVE(WRITE_ACTIVE),
    .ERASE_ACTIVE(ERASE_ACTIVE),
    .MASTER_RESET_PIN_SELECT(MASTER_RESET_PIN_SELECT),
    .READ_PROTECT_SELECT(READ_PROTECT_SELECT),
    .WATCHDOG_ENABLE_BIT(WATCHDOG_ENABLE_BIT),
    .OSCILLATOR_SOURCE_FIELD(OSCILLATOR_SOURCE_FIELD),
    .LOW_POWER_CRYSTAL(LOW_POWER_CRYSTAL),
    .STANDARD_CRYSTAL(STANDARD_CRYSTAL),
    .HIGH_SPEED_CRYSTAL(HIGH_SPEED_CRYSTAL),
    .EXTERNAL_CLOCK_INPUT(EXTERNAL_CLOCK_INPUT),
    .SHARED_GENERAL_INPUT(SHARED_GENERAL_INPUT),
    .SHARED_GENERAL_IO(SHARED_GENERAL_IO), .CORE_RESET_B(CORE_RESET_B));
  // 40 MHz system clock
  initial begin
    MCLK = 1'h0;
    forever #12.5 MCLK = ~MCLK;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [11:0] obs(input int s);
    case (s)
      0: return DEVICE_OPTION_WORD;
      1: return FETCH_DATA;
      2: return {1'h0, ADDRESS};
      3: return {2'h0, CORE_RESET_B, SHARED_GENERAL_IO, SHARED_GENERAL_INPUT,
        MASTER_RESET_PIN_SELECT, READ_PROTECT_SELECT, WATCHDOG_ENABLE_BIT,
        EXTERNAL_CLOCK_INPUT, HIGH_SPEED_CRYSTAL, STANDARD_CRYSTAL,
        LOW_POWER_CRYSTAL};
      default: return {10'h000, ERASE_ACTIVE, WRITE_ACTIVE};
    endcase
  endfunction
  // expected decodes for option bits, p is the level on the reset pin
  function automatic logic [11:0] dec(input logic [5:0] o, input logic p);
    logic [3:0] h;
    h = o[2] ? 4'h0 : 4'h1 << o[1:0];
    return {2'h0, o[5] ? p : 1'h1, h[3], !o[5], o[5], o[4], o[3], h};
  endfunction
  task automatic note(input int s, input logic [11:0] e);
    q.push_back('{s, e});
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // load then begin; a dropped increment inside the write; then end
  task automatic prog(input logic [11:0] w);
    prog_model_i.send_load(w);
    prog_model_i.send_cmd(6'h08);
    note(4, 12'h001);
    prog_model_i.send_cmd(6'h06);
    prog_model_i.send_cmd(6'h0e);
    note(4, 12'h000);
  endtask
  // erase, then a bounded wait for the self-timed end
  task automatic erase_wait;
    int i;
    prog_model_i.send_cmd(6'h09);
    note(4, 12'h002);
    for (i = 0; i < 200 && ERASE_ACTIVE !== 1'h0; i++) @(posedge MCLK);
    if (i == 200) begin
      n_mismatch++;
      summarize();
    end
    repeat (3) @(posedge MCLK);
  endtask
  // every queued note against the outputs, half a cycle after they launch
  always @(negedge MCLK) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      samples_checked++;
      if (obs(n.sel) !== n.val) begin
        n_mismatch++;
        $display("[ERR] %0t got %h exp %h", $time, obs(n.sel), n.val);
      end
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    RST_B = 1'h0;
    MASTER_RESET_INPUT_B = 1'h1;
    FETCH_ADDR = 10'h000;
    t = $urandom(32'hfb17);
    fork
      prog_model_i.clk_bits(16'h0000, 4);
      repeat (4) @(posedge MCLK);
    join
    RST_B <= 1'h1;
    MASTER_RESET_INPUT_B <= 1'h0;
    repeat (6) @(posedge MCLK);
    note(0, 12'hfff);
    note(2, 12'h7ff);
    note(3, dec(6'h3f, 1'h0));
    // link reset pipe drains only on two falling edges after release
    prog_model_i.clk_bits(16'h0000, 2);
    for (int k = 0; k < 4; k++) begin
      erase_wait();
      note(0, 12'hfff);
      v = {k[0], 2'($urandom), 3'(k)};
      FETCH_ADDR <= 10'($urandom);
      MASTER_RESET_INPUT_B <= k[1];
      prog({6'h00, v});
      note(0, {6'h3f, v});
      note(2, 12'h7ff);
      note(3, dec(v, MASTER_RESET_INPUT_B));
      note(1, 12'hfff);
    end
    @(posedge MCLK);
    FETCH_ADDR <= 10'h000;
    t = 12'($urandom);
    prog(t);
    note(0, {6'h3f, v & t[5:0]});
    prog_model_i.send_cmd(6'h06);
    note(2, 12'h000);
    prog(t);
    note(1, t);
    erase_wait();
    note(1, 12'hfff);
    note(0, 12'hfff);
    repeat (1023) prog_model_i.send_cmd(6'h06);
    @(posedge MCLK);
    FETCH_ADDR <= 10'h3ff;
    prog(t);
    note(1, t);
    prog_model_i.send_cmd(6'h06);
    note(2, 12'h400);
    erase_wait();
    note(1, 12'hfff);
    // the kept trim word goes back into the backup location
    repeat (4) prog_model_i.send_cmd(6'h06);
    prog(t);
    note(2, 12'h404);
    repeat (3) @(posedge MCLK);
    summarize();
  end
endmodule
